//--- iul1_pkg.sv
// shared constants and carrier types for the u-interface activation control block
package iul1_pkg;

	// register byte offsets on the axi4-lite bus
	localparam logic [7:0] OFS_GEN0 = 8'h00;
	localparam logic [7:0] OFS_GEN1 = 8'h04;
	localparam logic [7:0] OFS_GEN2 = 8'h08;
	localparam logic [7:0] OFS_DFL0 = 8'h0c;
	localparam logic [7:0] OFS_DFL1 = 8'h10;
	localparam logic [7:0] OFS_HWYC = 8'h14;
	localparam logic [7:0] OFS_STA1 = 8'h18;
	localparam logic [7:0] OFS_STA2 = 8'h1c;
	localparam logic [7:0] OFS_IRQ0 = 8'h20;
	localparam logic [7:0] OFS_IRQ1 = 8'h24;
	localparam logic [7:0] OFS_GIRQ = 8'h28;

	// field positions
	localparam int BIT_AUTO_ACT  = 6;
	localparam int BIT_HWY_DIS   = 5;
	localparam int BIT_XPAR_BLK  = 5;
	localparam int BIT_TX_ACT    = 4;
	localparam int BIT_SAI_HI    = 1;
	localparam int BIT_SAI_LO    = 0;
	localparam int BIT_ACT_RX    = 0;
	localparam int BIT_ACT_PROG  = 1;
	localparam int BIT_FSYNC     = 2;
	localparam int BIT_SC        = 3;
	localparam int BIT_GLOBAL    = 0;
	localparam int BIT_RX_HIZ_LO = 5;
	localparam int BIT_FS_POL    = 3;
	localparam logic [1:0] SAI_ACTIVE = 2'h1;

	// values after reset
	localparam logic [7:0] RST_GEN0 = 8'h40;
	localparam logic [7:0] RST_GEN1 = 8'h20;
	localparam logic [7:0] RST_GEN2 = 8'h20;
	localparam logic [7:0] RST_DFL0 = 8'h00;
	localparam logic [7:0] RST_DFL1 = 8'h00;
	localparam logic [7:0] RST_HWYC = 8'h0f;
	localparam logic [7:0] RST_IRQ1 = 8'h08;

	// least spacing between two register accesses
	localparam int CLK_HZ   = 40000000;
	localparam int GAP_NS   = 10000;
	localparam int GAP_CYC  = (GAP_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int GAP_W    = 9;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// line-side indications from the transceiver core
	typedef struct packed {
		logic wake;
		logic sync_ok;
		logic act_rx;
		logic fail;
	} iul1_line_in_s;

	// line-side controls towards the transceiver core
	typedef struct packed {
		logic startup_req;
		logic tx_act;
		logic st_activity;
		logic up_transparent;
	} iul1_line_out_s;

	// tdm highway configuration
	typedef struct packed {
		logic       hwy_en;
		logic [7:0] tx_cfg;
		logic [7:0] rx_cfg;
		logic [2:0] rx_oe;
		logic       fs_pol;
		logic [2:0] fs_pos;
	} iul1_hwy_s;

endpackage : iul1_pkg

//--- iul1_sync.sv
// three-stage input synchroniser that accepts a change once two stages agree
`timescale 1ns/100ps
module iul1_sync #(
	parameter int W = 4
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} iul1_sync_s;

	iul1_sync_s s_r;
	iul1_sync_s s_nxt;

	// shift chain; output follows only where stages two and three agree
	always_comb begin
		s_nxt    = s_r;
		s_nxt.s1 = din;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		for (int i = 0; i < W; i++) begin
			if (s_r.s2[i] == s_r.s3[i]) begin
				s_nxt.q[i] = s_r.s3[i];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign dout = s_r.q;

endmodule : iul1_sync

//--- iul1_ctrl.sv
// u-interface layer-1 activation control with axi4-lite register bank
// Summary of operation
// - highway runs when software clears highway_disable, bit 5 of general_reg_two.
// - data_flow_reg_zero value F5h enables transmit B channels on highway.
// - data_flow_reg_one value 1Eh enables transmit D and receive B1, B2, D.
// - data_flow_reg_one bits 7..5 float each receive channel output individually.
// - highway_config_reg sets strobe position and polarity; reset gives positive B1 strobe.
// - writing auto_activation_bit zero while idle starts start-up and sets activation_in_progress.
// - auto_activation_bit returns to one by itself on the clock after the write, whether or not start-up begins.
// - switch start-up sets activation_in_progress; interrupt only when status_change_mask clear.
// - status_change_flag sets when any bit of status_reg_one or two changes.
// - S/T-activity field value 01 reports S/T activity to the switch.
// - failed start-up shows as activation_in_progress returning to zero.
// - frame_sync_indicator goes high on synchronisation and raises a status change.
// - transmit_activation bit makes the device send upstream activation as one.
// - received_activation sets status bit 0 and opens upstream transparency itself.
// - each access is command then data; at least 10 us between accesses.
`timescale 1ns/100ps
module iul1_ctrl (
	input  wire logic                    clk,
	input  wire logic                    rst,
	// axi4-lite slave
	input  wire logic [7:0]              s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [7:0]              s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	// transceiver core side
	input  wire iul1_pkg::iul1_line_in_s line_in,
	output iul1_pkg::iul1_line_out_s     line_out,
	output iul1_pkg::iul1_hwy_s          hwy,
	output logic                         irq
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_START,
		ST_SYNC,
		ST_ACT
	} iul1_act_e;

	typedef struct packed {
		logic                     aw_have;
		logic [7:0]               aw_addr;
		logic                     w_have;
		logic [7:0]               w_data;
		logic                     w_en;
		logic                     bvalid;
		logic [1:0]               bresp;
		logic                     rvalid;
		logic [7:0]               rdata;
		logic [1:0]               rresp;
		logic [iul1_pkg::GAP_W-1:0] gap;
		logic [7:0]               gen0;
		logic [7:0]               gen1;
		logic [7:0]               gen2;
		logic [7:0]               dfl0;
		logic [7:0]               dfl1;
		logic [7:0]               hwyc;
		logic [7:0]               irq1;
		logic [7:0]               sta1_prev;
		logic [7:0]               sta2_prev;
		logic                     sc_flag;
		iul1_act_e                act;
		logic                     startup_req;
	} iul1_state_s;

	iul1_state_s          s_r;
	iul1_state_s          s_nxt;
	iul1_pkg::iul1_line_in_s ln;
	logic [7:0]           sta1;
	logic [7:0]           sta2;
	logic                 gap_idle;
	logic                 do_wr;
	logic                 do_rd;
	logic                 global_irq;

	// line indications come from another domain
	iul1_sync #(
		.W ($bits(iul1_pkg::iul1_line_in_s))
	) u_sync (
		.clk  (clk),
		.rst  (rst),
		.din  (line_in),
		.dout (ln)
	);

	// register read decode
	function automatic logic [8:0] rd_mux(input iul1_state_s s, input logic [7:0] a,
		input logic [7:0] st1, input logic [7:0] st2, input logic gi);
		logic [8:0] r;
		r = {1'b1, 8'h00};
		unique case (a)
			iul1_pkg::OFS_GEN0: r = {1'b1, s.gen0};
			iul1_pkg::OFS_GEN1: r = {1'b1, s.gen1};
			iul1_pkg::OFS_GEN2: r = {1'b1, s.gen2};
			iul1_pkg::OFS_DFL0: r = {1'b1, s.dfl0};
			iul1_pkg::OFS_DFL1: r = {1'b1, s.dfl1};
			iul1_pkg::OFS_HWYC: r = {1'b1, s.hwyc};
			iul1_pkg::OFS_STA1: r = {1'b1, st1};
			iul1_pkg::OFS_STA2: r = {1'b1, st2};
			iul1_pkg::OFS_IRQ0: r = {1'b1, 4'h0, s.sc_flag, 3'h0};
			iul1_pkg::OFS_IRQ1: r = {1'b1, s.irq1};
			iul1_pkg::OFS_GIRQ: r = {1'b1, 7'h00, gi};
			default:            r = {1'b0, 8'h00};
		endcase
		return r;
	endfunction : rd_mux

	// status register one built from the activation state, status register two from the line indications
	always_comb begin
		sta1 = 8'h00;
		sta1[iul1_pkg::BIT_ACT_RX] = (s_r.act == ST_ACT);
		sta1[iul1_pkg::BIT_ACT_PROG] = (s_r.act != ST_IDLE);
		sta1[iul1_pkg::BIT_FSYNC] = (s_r.act == ST_SYNC) || (s_r.act == ST_ACT);
		sta2 = {6'h00, ln.fail, ln.wake};
	end

	assign global_irq = s_r.sc_flag && !s_r.irq1[iul1_pkg::BIT_SC];
	assign gap_idle = (s_r.gap == '0);
	assign do_wr = s_r.aw_have && s_r.w_have && !s_r.bvalid;
	assign do_rd = s_axi_arvalid && s_axi_arready;

	// next-state logic for bus, registers and activation
	always_comb begin
		logic [8:0] rd;
		logic       rd_hit;
		rd     = 9'h000;
		rd_hit = 1'b0;
		s_nxt  = s_r;
		s_nxt.startup_req = 1'b0;
		s_nxt.sta1_prev = sta1;
		s_nxt.sta2_prev = sta2;
		if (s_r.gap != '0) begin
			s_nxt.gap = s_r.gap - 1'b1;
		end
		// address and data captured in either order
		if (s_axi_awvalid && s_axi_awready) begin
			s_nxt.aw_have = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_nxt.w_have = 1'b1;
			s_nxt.w_data = s_axi_wdata[7:0];
			s_nxt.w_en   = s_axi_wstrb[0];
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (!s_r.gen0[iul1_pkg::BIT_AUTO_ACT]) begin
			s_nxt.gen0[iul1_pkg::BIT_AUTO_ACT] = 1'b1;
		end
		// register write
		if (do_wr) begin
			s_nxt.aw_have = 1'b0;
			s_nxt.w_have  = 1'b0;
			s_nxt.bvalid  = 1'b1;
			s_nxt.bresp   = iul1_pkg::RESP_OKAY;
			s_nxt.gap     = iul1_pkg::GAP_W'(iul1_pkg::GAP_CYC);
			if (s_r.w_en) begin
				unique case (s_r.aw_addr)
					iul1_pkg::OFS_GEN0: s_nxt.gen0 = s_r.w_data;
					iul1_pkg::OFS_GEN1: s_nxt.gen1 = s_r.w_data;
					iul1_pkg::OFS_GEN2: s_nxt.gen2 = s_r.w_data;
					iul1_pkg::OFS_DFL0: s_nxt.dfl0 = s_r.w_data;
					iul1_pkg::OFS_DFL1: s_nxt.dfl1 = s_r.w_data;
					iul1_pkg::OFS_HWYC: s_nxt.hwyc = s_r.w_data;
					iul1_pkg::OFS_IRQ1: s_nxt.irq1 = s_r.w_data;
					iul1_pkg::OFS_STA1, iul1_pkg::OFS_STA2, iul1_pkg::OFS_IRQ0,
					iul1_pkg::OFS_GIRQ: ;
					default: s_nxt.bresp = iul1_pkg::RESP_SLVERR;
				endcase
			end
		end
		// register read
		if (do_rd) begin
			rd = rd_mux(s_r, s_axi_araddr, sta1, sta2, global_irq);
			rd_hit = rd[8];
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata  = rd[7:0];
			s_nxt.rresp  = rd_hit ? iul1_pkg::RESP_OKAY : iul1_pkg::RESP_SLVERR;
			s_nxt.gap    = iul1_pkg::GAP_W'(iul1_pkg::GAP_CYC);
			if (s_axi_araddr == iul1_pkg::OFS_IRQ0) begin
				s_nxt.sc_flag = 1'b0;
			end
		end
		// any status change sets the flag, set wins
		if ((sta1 != s_r.sta1_prev) || (sta2 != s_r.sta2_prev)) begin
			s_nxt.sc_flag = 1'b1;
		end
		// activation sequence
		unique case (s_r.act)
			ST_IDLE: begin
				if (!s_r.gen0[iul1_pkg::BIT_AUTO_ACT]) begin
					s_nxt.act         = ST_START;
					s_nxt.startup_req = 1'b1;
				end else if (ln.wake) begin
					s_nxt.act = ST_START;
				end
			end
			ST_START: begin
				if (ln.fail) begin
					s_nxt.act = ST_IDLE;
				end else if (ln.sync_ok) begin
					s_nxt.act = ST_SYNC;
				end
			end
			ST_SYNC: begin
				if (ln.fail || !ln.sync_ok) begin
					s_nxt.act = ST_IDLE;
				end else if (ln.act_rx) begin
					s_nxt.act = ST_ACT;
				end
			end
			ST_ACT: begin
				if (ln.fail || !ln.sync_ok) begin
					s_nxt.act = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r      <= '0;
			s_r.gen0 <= iul1_pkg::RST_GEN0;
			s_r.gen1 <= iul1_pkg::RST_GEN1;
			s_r.gen2 <= iul1_pkg::RST_GEN2;
			s_r.dfl0 <= iul1_pkg::RST_DFL0;
			s_r.dfl1 <= iul1_pkg::RST_DFL1;
			s_r.hwyc <= iul1_pkg::RST_HWYC;
			s_r.irq1 <= iul1_pkg::RST_IRQ1;
			s_r.act  <= ST_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// bus handshakes
	assign s_axi_awready = !s_r.aw_have && !s_r.bvalid && gap_idle;
	assign s_axi_wready  = !s_r.w_have && !s_r.bvalid && gap_idle;
	assign s_axi_arready = !s_r.rvalid && gap_idle && !do_wr;
	assign s_axi_bvalid  = s_r.bvalid;
	assign s_axi_bresp   = s_r.bresp;
	assign s_axi_rvalid  = s_r.rvalid;
	assign s_axi_rresp   = s_r.rresp;
	assign s_axi_rdata   = {24'h000000, s_r.rdata};
	assign irq           = global_irq;

	// line-side controls
	always_comb begin
		line_out.startup_req = s_r.startup_req;
		line_out.tx_act = s_r.gen1[iul1_pkg::BIT_TX_ACT];
		line_out.st_activity =
			(s_r.gen1[iul1_pkg::BIT_SAI_HI:iul1_pkg::BIT_SAI_LO] == iul1_pkg::SAI_ACTIVE);
		line_out.up_transparent = (s_r.act == ST_ACT) || !s_r.gen1[iul1_pkg::BIT_XPAR_BLK];
	end

	// highway configuration
	always_comb begin
		hwy.hwy_en = !s_r.gen2[iul1_pkg::BIT_HWY_DIS];
		hwy.tx_cfg = s_r.dfl0;
		hwy.rx_cfg = s_r.dfl1;
		hwy.rx_oe  = {3{hwy.hwy_en}} & ~s_r.dfl1[iul1_pkg::BIT_RX_HIZ_LO+2:iul1_pkg::BIT_RX_HIZ_LO];
		hwy.fs_pol = s_r.hwyc[iul1_pkg::BIT_FS_POL];
		hwy.fs_pos = s_r.hwyc[2:0];
	end

endmodule : iul1_ctrl

//--- iul1_ctrl_monitor.sv
// port checker for the activation control block
`timescale 1ns/100ps
module iul1_ctrl_monitor (
	input wire logic                     clk,
	input wire logic                     rst,
	input wire logic                     s_axi_awvalid,
	input wire logic                     s_axi_awready,
	input wire logic                     s_axi_wvalid,
	input wire logic                     s_axi_wready,
	input wire logic [1:0]               s_axi_bresp,
	input wire logic                     s_axi_bvalid,
	input wire logic                     s_axi_bready,
	input wire logic                     s_axi_arvalid,
	input wire logic                     s_axi_arready,
	input wire logic [31:0]              s_axi_rdata,
	input wire logic                     s_axi_rvalid,
	input wire logic                     s_axi_rready,
	input wire iul1_pkg::iul1_line_out_s line_out,
	input wire iul1_pkg::iul1_hwy_s      hwy
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// receive outputs float per bit
	a_rx_float: assert property (
		hwy.rx_oe == ({3{hwy.hwy_en}} & ~hwy.rx_cfg[7:5]))
		else $error("receive enables wrong");
	// strobe default after reset
	a_fs_reset: assert property (
		$fell(rst) |-> hwy.fs_pol && hwy.fs_pos == 3'h7)
		else $error("strobe default wrong");
	// start-up request is a single pulse
	a_start_pulse: assert property (
		line_out.startup_req |=> !line_out.startup_req)
		else $error("start-up pulse too long");
	// write answer after both halves: capture edge, then execute edge
	a_wr_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write not answered");
	// read answer next cycle
	a_rd_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	// access spacing keeps arready low after a read
	a_gap_quiet: assert property (
		s_axi_arvalid && s_axi_arready |=> !s_axi_arready [*8])
		else $error("access spacing broken");
	// write response held
	a_b_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	// read response held
	a_r_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response dropped");
	// registers are one byte wide
	a_rd_narrow: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data too wide");
endmodule : iul1_ctrl_monitor

bind iul1_ctrl iul1_ctrl_monitor u_mon (.clk, .rst, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.line_out, .hwy);

//--- iul1_switch_model.sv
// behavioural line termination at the far end of the loop
`timescale 1ns/100ps
module iul1_switch_model (
	input wire logic                     clk,
	input wire logic                     rst,
	input wire iul1_pkg::iul1_line_out_s line_out,
	input wire logic                     wake_cmd,
	input wire logic                     fail_cmd,
	output iul1_pkg::iul1_line_in_s      line_in
);
	logic       run;
	logic [5:0] cnt;
	// start-up, sync and activation sequencing
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			run <= 1'b0;
			cnt <= 6'h0;
			line_in <= '0;
		end else begin
			line_in.wake <= wake_cmd;
			line_in.fail <= fail_cmd;
			if (fail_cmd)
				run <= 1'b0;
			else if (line_out.startup_req || wake_cmd)
				run <= 1'b1;
			cnt <= run ? cnt + {5'h0, cnt != 6'h3f} : 6'h0;
			line_in.sync_ok <= run && cnt > 6'd20;
			line_in.act_rx <= run && cnt > 6'd40 && line_out.tx_act;
		end
	end
endmodule : iul1_switch_model

//--- iul1_ctrl_tb.sv
// self-checking bench for the activation control block
`timescale 1ns/100ps
module iul1_ctrl_tb;
	logic                     clk = 0;
	logic                     rst = 1;
	logic [7:0]               s_axi_awaddr = 0;
	logic [7:0]               s_axi_araddr = 0;
	logic [31:0]              s_axi_wdata = 0;
	logic [3:0]               s_axi_wstrb = 4'hf;
	logic                     s_axi_awvalid = 0;
	logic                     s_axi_wvalid = 0;
	logic                     s_axi_bready = 0;
	logic                     s_axi_arvalid = 0;
	logic                     s_axi_rready = 0;
	logic                     wake_cmd = 0;
	logic                     fail_cmd = 0;
	logic                     s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic                     s_axi_arready, s_axi_rvalid, irq;
	logic [1:0]               s_axi_bresp, s_axi_rresp;
	logic [31:0]              s_axi_rdata;
	iul1_pkg::iul1_line_in_s  line_in;
	iul1_pkg::iul1_line_out_s line_out;
	iul1_pkg::iul1_hwy_s      hwy;
	int                       err_count = 0;
	int                       n_checks = 0;
	int                       n_start = 0;

	always #12.5 clk = ~clk;

	iul1_ctrl dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .line_in, .line_out, .hwy, .irq);
	iul1_switch_model u_sw (.clk, .rst, .line_out, .wake_cmd, .fail_cmd, .line_in);

	// counts start-up pulses
	always @(posedge clk) if (line_out.startup_req === 1'b1) n_start++;

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("Error at %0t: got %h, expected %h", $time, g, e);
		end
	endtask : chk

	task automatic wt(input int c);
		repeat (c) @(posedge clk);
	endtask : wt

	// one write, both halves offered together
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic sa, sw, sb;
		logic [1:0] rb;
		int n;
		n = 0;
		sb = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!sb && n < 2000) begin
			@(negedge clk);
			sa = s_axi_awvalid && s_axi_awready;
			sw = s_axi_wvalid && s_axi_wready;
			sb = s_axi_bvalid;
			rb = s_axi_bresp;
			@(posedge clk);
			n++;
			if (sa) s_axi_awvalid <= 0;
			if (sw) s_axi_wvalid <= 0;
		end
		s_axi_bready <= 0;
		@(posedge clk);
		chk({31'h0, sb}, 32'h1);
		chk({30'h0, rb}, 32'h0);
	endtask : wr

	// one read, data and response compared
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r = 2'h0);
		logic sa, sb;
		logic [31:0] d;
		logic [1:0] rr;
		int n;
		n = 0;
		sb = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		while (!sb && n < 2000) begin
			@(negedge clk);
			sa = s_axi_arvalid && s_axi_arready;
			sb = s_axi_rvalid;
			d = s_axi_rdata;
			rr = s_axi_rresp;
			@(posedge clk);
			n++;
			if (sa) s_axi_arvalid <= 0;
		end
		s_axi_rready <= 0;
		@(posedge clk);
		chk({31'h0, sb}, 32'h1);
		chk(d, {24'h0, e});
		chk({30'h0, rr}, {30'h0, r});
	endtask : rd

	task automatic t_reset;
		rd(iul1_pkg::OFS_GEN0, 8'h40);
		rd(iul1_pkg::OFS_GEN1, 8'h20);
		rd(iul1_pkg::OFS_HWYC, 8'h0f);
		rd(iul1_pkg::OFS_IRQ1, 8'h08);
		chk({27'h0, hwy.hwy_en, hwy.fs_pol, hwy.fs_pos}, 32'hf);
		$display("t_reset done");
	endtask : t_reset

	task automatic t_hwy;
		wr(iul1_pkg::OFS_GEN2, 8'h00);
		chk({31'h0, hwy.hwy_en}, 32'h1);
		wr(iul1_pkg::OFS_DFL0, 8'hf5);
		chk({24'h0, hwy.tx_cfg}, 32'hf5);
		wr(iul1_pkg::OFS_DFL1, 8'h1e);
		chk({21'h0, hwy.rx_cfg, hwy.rx_oe}, {21'h0, 8'h1e, 3'h7});
		wr(iul1_pkg::OFS_DFL1, 8'hbe);
		chk({29'h0, hwy.rx_oe}, 32'h2);
		rd(8'h3c, 8'h00, 2'h2);
		$display("t_hwy done");
	endtask : t_hwy

	task automatic t_wake;
		wake_cmd <= 1;
		wt(40);
		rd(iul1_pkg::OFS_STA1, 8'h06);
		chk({31'h0, irq}, 32'h0);
		rd(iul1_pkg::OFS_STA2, 8'h01);
		rd(iul1_pkg::OFS_GIRQ, 8'h00);
		wake_cmd <= 0;
		fail_cmd <= 1;
		wt(10);
		fail_cmd <= 0;
		wt(10);
		rd(iul1_pkg::OFS_STA1, 8'h00);
		rd(iul1_pkg::OFS_IRQ0, 8'h08);
		rd(iul1_pkg::OFS_IRQ0, 8'h00);
		$display("t_wake done");
	endtask : t_wake

	// local request then wait for status
	task automatic t_local;
		wr(iul1_pkg::OFS_IRQ1, 8'h00);
		wr(iul1_pkg::OFS_GEN1, 8'h21);
		chk({31'h0, line_out.st_activity}, 32'h1);
		wr(iul1_pkg::OFS_GEN0, 8'h00);
		rd(iul1_pkg::OFS_GEN0, 8'h40);
		chk({31'h0, irq}, 32'h1);
		rd(iul1_pkg::OFS_STA1, 8'h06);
		rd(iul1_pkg::OFS_GIRQ, 8'h01);
		rd(iul1_pkg::OFS_IRQ0, 8'h08);
		chk({31'h0, irq}, 32'h0);
		wr(iul1_pkg::OFS_GEN1, 8'h31);
		chk({31'h0, line_out.tx_act}, 32'h1);
		wt(60);
		rd(iul1_pkg::OFS_STA1, 8'h07);
		chk({31'h0, line_out.up_transparent}, 32'h1);
		fail_cmd <= 1;
		wt(10);
		fail_cmd <= 0;
		wt(10);
		rd(iul1_pkg::OFS_STA1, 8'h00);
		wr(iul1_pkg::OFS_GEN1, 8'h21);
		chk({30'h0, line_out.tx_act, line_out.up_transparent}, 32'h0);
		wr(iul1_pkg::OFS_GEN0, 8'h00);
		// start-up pulse lands one edge after the write
		wt(2);
		chk(n_start, 32'h2);
		$display("t_local done");
	endtask : t_local

	task automatic close_out;
		$display("checks %0d, mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out

	// main sequence
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		t_reset;
		t_hwy;
		t_wake;
		t_local;
		close_out;
	end

	// watchdog against a hang
	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		close_out;
	end
endmodule : iul1_ctrl_tb
